// file: rtl/tss_slave.v
// two-wire serial slave port: start/stop, address match, pointer, data bytes
// assumes register storage lives outside; clock pin is sampled, not used as a clock
`timescale 1ns/1ns
`include "tss_defines.vh"
module tss_slave #(
  parameter TOUT_CYC = `TSS_TOUT_CYC,
  parameter TOUT_W   = 24
) (
  // clock, reset, enable
  input  wire        mclk_in,
  input  wire        rstn_in,
  input  wire        ce_in,
  // serial clock pin, input only
  input  wire        scl_in,
  // serial data pin, open drain
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe_out,
  // address straps
  input  wire        addr_strap_bit0_in,
  input  wire        addr_strap_bit1_in,
  input  wire        addr_strap_bit2_in,
  // register side
  input  wire [15:0] rd_data_in,
  output reg  [7:0]  reg_ptr_out,
  output reg         ptr_wr_out,
  output reg  [7:0]  wr_data_out,
  output reg         wr_strobe_out,
  output reg         rd_load_out,
  output reg         busy_out,
  output reg         end_of_transfer_marker_out,
  // alert pin, open drain
  input  wire        alert_req_in,
  output reg         alert_out,
  output reg         alert_oe_out
);
  localparam [7:0] ST_IDLE  = 8'h01;
  localparam [7:0] ST_ADDR  = 8'h02;
  localparam [7:0] ST_AACK  = 8'h04;
  localparam [7:0] ST_WRX   = 8'h08;
  localparam [7:0] ST_WACK  = 8'h10;
  localparam [7:0] ST_RTX   = 8'h20;
  localparam [7:0] ST_RACK  = 8'h40;
  localparam [7:0] ST_SKIP  = 8'h80;

  wire [`TSS_SYNC_W-1:0] sync_w;
  wire                   scl_s;
  wire                   sda_s;
  wire [2:0]             strap_s;
  wire                   tout_w;

  reg        scl_d_r;
  reg        sda_d_r;
  reg [7:0]  state_r;
  reg [7:0]  state_nxt;
  reg [3:0]  cnt_r;
  reg [3:0]  cnt_nxt;
  reg [7:0]  rx_r;
  reg [7:0]  rx_nxt;
  reg [7:0]  tx_r;
  reg [7:0]  tx_nxt;
  reg [15:0] word_r;
  reg [15:0] word_nxt;
  reg        hi_r;
  reg        hi_nxt;
  reg        first_r;
  reg        first_nxt;
  reg        nak_r;
  reg        nak_nxt;
  reg        oe_nxt;
  reg [7:0]  ptr_nxt;
  reg        ptr_wr_nxt;
  reg [7:0]  wdat_nxt;
  reg        wstb_nxt;
  reg        rld_nxt;
  reg        eot_nxt;

  // fixed code on top, straps below
  function addr_match;
    input [6:0] rx_addr;
    input [2:0] straps;
    begin
      addr_match = (rx_addr == {`TSS_ADDR_CODE, straps});
    end
  endfunction

  // open drain: enable the low driver for a zero bit
  function drive_low;
    input data_bit;
    begin
      drive_low = ~data_bit;
    end
  endfunction

  // one received bit enters the byte from the bottom, msb first
  function [7:0] shift_in;
    input [7:0] acc;
    input       data_bit;
    begin
      shift_in = {acc[6:0], data_bit};
    end
  endfunction

  // bit counter step, shared by the receive and send paths
  function [3:0] cnt_inc;
    input [3:0] cnt;
    begin
      cnt_inc = cnt + 4'h1;
    end
  endfunction

  // half of the held word that goes out next; the pointer never moves
  function [7:0] word_byte;
    input [15:0] word;
    input        high;
    begin
      word_byte = high ? word[15:8] : word[7:0];
    end
  endfunction

  tss_sync #(
    .W (`TSS_SYNC_W)
  ) u_sync (
    .mclk_in  (mclk_in),
    .rstn_in  (rstn_in),
    .ce_in    (ce_in),
    .async_in ({scl_in, sda_in, addr_strap_bit2_in, addr_strap_bit1_in,
                addr_strap_bit0_in}),
    .sync_out (sync_w)
  );

  // edges are found only on synchronised samples
  assign scl_s   = sync_w[4];
  assign sda_s   = sync_w[3];
  assign strap_s = sync_w[2:0];

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  // data moving while clock stays high is a start or stop
  wire start_w  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_w   = scl_s & scl_d_r & ~sda_d_r & sda_s;

  tss_timeout #(
    .CW   (TOUT_W),
    .TOUT (TOUT_CYC)
  ) u_tout (
    .mclk_in     (mclk_in),
    .rstn_in     (rstn_in),
    .ce_in       (ce_in),
    .scl_edge_in (scl_rise | scl_fall),
    .expire_out  (tout_w)
  );

  always @* begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    rx_nxt     = rx_r;
    tx_nxt     = tx_r;
    word_nxt   = word_r;
    hi_nxt     = hi_r;
    first_nxt  = first_r;
    nak_nxt    = nak_r;
    oe_nxt     = sda_oe_out;
    ptr_nxt    = reg_ptr_out;
    ptr_wr_nxt = 1'b0;
    wdat_nxt   = wr_data_out;
    wstb_nxt   = 1'b0;
    rld_nxt    = 1'b0;
    eot_nxt    = 1'b0;
    if (tout_w) begin
      // stuck clock: drop everything, keep the pointer
      // a stall with the clock high may let go of data while it is high
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
    end else if (stop_w) begin
      // release at once, even mid byte
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
    end else if (start_w) begin
      // any start, repeated or mid-transfer, opens a new address phase
      state_nxt = ST_ADDR;
      cnt_nxt   = 4'h0;
      oe_nxt    = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // idle is both lines high; nothing moves until a start
          oe_nxt = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            rx_nxt  = shift_in(rx_r, sda_s);
            cnt_nxt = cnt_inc(cnt_r);
          end else if (scl_fall && cnt_r == `TSS_BIT_LAST) begin
            if (addr_match(rx_r[7:1], strap_s)) begin
              oe_nxt    = 1'b1;
              state_nxt = ST_AACK;
            end else begin
              state_nxt = ST_SKIP;
            end
          end
        end
        ST_AACK: begin
          // the ack bit is held across the master's extra pulse
          if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (rx_r[0]) begin
              // read: send the word of the kept pointer
              word_nxt  = rd_data_in;
              tx_nxt    = word_byte(rd_data_in, 1'b1);
              hi_nxt    = 1'b0;
              rld_nxt   = 1'b1;
              oe_nxt    = drive_low(rd_data_in[15]);
              state_nxt = ST_RTX;
            end else begin
              oe_nxt    = 1'b0;
              first_nxt = 1'b1;
              state_nxt = ST_WRX;
            end
          end
        end
        ST_WRX: begin
          if (scl_rise) begin
            rx_nxt  = shift_in(rx_r, sda_s);
            cnt_nxt = cnt_inc(cnt_r);
          end else if (scl_fall && cnt_r == `TSS_BIT_LAST) begin
            oe_nxt    = 1'b1;
            state_nxt = ST_WACK;
            if (first_r) begin
              // first byte is the whole eight-bit pointer
              ptr_nxt    = rx_r;
              ptr_wr_nxt = 1'b1;
              first_nxt  = 1'b0;
            end else begin
              // later bytes go to the same register, msb first
              wdat_nxt = rx_r;
              wstb_nxt = 1'b1;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            oe_nxt    = 1'b0;
            cnt_nxt   = 4'h0;
            state_nxt = ST_WRX;
          end
        end
        ST_RTX: begin
          if (scl_fall) begin
            if (cnt_r == `TSS_TX_LAST) begin
              // let go so the master can answer
              oe_nxt    = 1'b0;
              cnt_nxt   = 4'h0;
              state_nxt = ST_RACK;
            end else begin
              // change data only after the clock has fallen
              tx_nxt  = {tx_r[6:0], 1'b0};
              oe_nxt  = drive_low(tx_r[6]);
              cnt_nxt = cnt_inc(cnt_r);
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nak_nxt = sda_s;
          end else if (scl_fall) begin
            if (nak_r) begin
              // released slot ends the read; stay off the line
              eot_nxt   = 1'b1;
              oe_nxt    = 1'b0;
              state_nxt = ST_SKIP;
            end else begin
              // no increment: the same word repeats, high byte then low
              tx_nxt    = word_byte(word_r, hi_r);
              oe_nxt    = drive_low(hi_r ? word_r[15] : word_r[7]);
              hi_nxt    = ~hi_r;
              state_nxt = ST_RTX;
            end
          end
        end
        ST_SKIP: begin
          // silent until the next start or stop
          oe_nxt = 1'b0;
        end
        default: begin
          state_nxt = ST_IDLE;
          oe_nxt    = 1'b0;
        end
      endcase
    end
  end

  // the slave never drives the clock pin; it only follows the master
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_d_r                    <= 1'b1;
      sda_d_r                    <= 1'b1;
      state_r                    <= ST_IDLE;
      cnt_r                      <= 4'h0;
      rx_r                       <= 8'h00;
      tx_r                       <= 8'h00;
      word_r                     <= 16'h0000;
      hi_r                       <= 1'b0;
      first_r                    <= 1'b0;
      nak_r                      <= 1'b0;
      sda_out                    <= 1'b0;
      sda_oe_out                 <= 1'b0;
      reg_ptr_out                <= `TSS_PTR_RST;
      ptr_wr_out                 <= 1'b0;
      wr_data_out                <= 8'h00;
      wr_strobe_out              <= 1'b0;
      rd_load_out                <= 1'b0;
      busy_out                   <= 1'b0;
      end_of_transfer_marker_out <= 1'b0;
      alert_out                  <= 1'b0;
      alert_oe_out               <= 1'b0;
    end else if (ce_in) begin
      scl_d_r                    <= scl_s;
      sda_d_r                    <= sda_s;
      state_r                    <= state_nxt;
      cnt_r                      <= cnt_nxt;
      rx_r                       <= rx_nxt;
      tx_r                       <= tx_nxt;
      word_r                     <= word_nxt;
      hi_r                       <= hi_nxt;
      first_r                    <= first_nxt;
      nak_r                      <= nak_nxt;
      sda_out                    <= 1'b0;
      sda_oe_out                 <= oe_nxt;
      reg_ptr_out                <= ptr_nxt;
      ptr_wr_out                 <= ptr_wr_nxt;
      wr_data_out                <= wdat_nxt;
      wr_strobe_out              <= wstb_nxt;
      rd_load_out                <= rld_nxt;
      // busy follows the next state so it drops together with the return to idle
      busy_out                   <= (state_nxt != ST_IDLE);
      end_of_transfer_marker_out <= eot_nxt;
      // open drain: the data level is always low, only the enable moves
      alert_out                  <= 1'b0;
      alert_oe_out               <= alert_req_in;
    end
  end
endmodule // tss_slave

// file: rtl/tss_defines.vh
// constants for the two-wire serial slave port of the temperature sensor
// assumes a 250 MHz system clock and a bus master that owns the serial clock
`ifndef TSS_DEFINES_VH
`define TSS_DEFINES_VH

`define TSS_ADDR_CODE   4'h3
`define TSS_ADDR_W      7
`define TSS_BYTE_W      8
`define TSS_WORD_W      16
`define TSS_PTR_RST     8'h00
`define TSS_BIT_LAST    4'h8
`define TSS_TX_LAST     4'h7
`define TSS_CLK_KHZ     250000
`define TSS_TOUT_MS     25
`define TSS_TOUT_CYC    (`TSS_TOUT_MS * `TSS_CLK_KHZ)
`define TSS_SYNC_W      5

`endif

// file: rtl/tss_sync.v
// two-stage synchroniser for pins from outside the clock domain
// assumes the inputs are slow levels; only the second stage is visible
`timescale 1ns/1ns
module tss_sync #(
  parameter W = 5
) (
  // clock and reset
  input  wire         mclk_in,
  input  wire         rstn_in,
  input  wire         ce_in,
  // levels
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // the reset value is all ones so idle lines look released
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_r <= {W{1'b1}};
      sync_r <= {W{1'b1}};
    end else if (ce_in) begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // tss_sync

// file: rtl/tss_timeout.v
// stuck-clock watchdog for the serial clock
// assumes the clock level is already synchronised
`timescale 1ns/1ns
module tss_timeout #(
  parameter CW   = 24,
  parameter TOUT = 6250000
) (
  // clock and reset
  input  wire mclk_in,
  input  wire rstn_in,
  input  wire ce_in,
  // serial clock activity
  input  wire scl_edge_in,
  output reg  expire_out
);
  reg [CW-1:0] cnt_r;

  // counts both stuck-low and stuck-high, any edge restarts it
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r      <= {CW{1'b0}};
      expire_out <= 1'b0;
    end else if (ce_in) begin
      expire_out <= 1'b0;
      if (scl_edge_in) begin
        cnt_r <= {CW{1'b0}};
      end else if (cnt_r == TOUT[CW-1:0] - 1'b1) begin
        cnt_r      <= {CW{1'b0}};
        expire_out <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule // tss_timeout

// file: verif/tss_master.sv
// bus master model that owns the serial clock and drives the data wire
// assumes the bench resolves the open-drain data wire, pulled up when released
`timescale 1ns/1ns
module tss_master (
  // clock
  input  wire mclk_in,
  // bus wires
  input  wire sda_in,
  output reg  scl_out,
  output reg  sda_out
);
  reg r;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task hc(input integer n);
    repeat (n) @(posedge mclk_in);
  endtask
  // data moves mid-low so that hold after the clock fall is kept
  task bit_x(input b, output s);
    hc(5);
    sda_out <= b;
    hc(5);
    scl_out <= 1'b1;
    hc(10);
    s = sda_in;
    scl_out <= 1'b0;
  endtask
  task start;
    hc(5);
    sda_out <= 1'b1;
    hc(5);
    scl_out <= 1'b1;
    hc(10);
    sda_out <= 1'b0;
    hc(10);
    scl_out <= 1'b0;
  endtask
  task stop;
    hc(5);
    sda_out <= 1'b0;
    hc(5);
    scl_out <= 1'b1;
    hc(10);
    sda_out <= 1'b1;
    hc(10);
  endtask
  // extra low time after the ack lets the slave's answer settle
  task wbyte(input [7:0] v, output ack);
    integer i;
    for (i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'b1, r);
    ack = ~r;
    hc(8);
  endtask
  task rbyte(input nak, output [7:0] v);
    integer i;
    for (i = 0; i < 8; i++) begin
      bit_x(1'b1, r);
      v = {v[6:0], r};
    end
    bit_x(nak, r);
    hc(8);
  endtask
endmodule // tss_master

// file: verif/tss_slave_properties.sv
// assertions for the two-wire serial slave port
// assumes it is bound into the slave and sees only its ports
`timescale 1ns/1ns
module tss_chk #(
  parameter TOUT_CYC = 2000
) (
  input wire       mclk_in,
  input wire       rstn_in,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_oe_out,
  input wire       alert_req_in,
  input wire       alert_out,
  input wire       alert_oe_out,
  input wire [7:0] reg_ptr_out,
  input wire       ptr_wr_out,
  input wire       wr_strobe_out,
  input wire       busy_out,
  input wire       end_of_transfer_marker_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // stuck span seen on the raw pin; margin covers synchroniser lag
  reg     scl_r;
  integer still_r;
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_r   <= 1'b1;
      still_r <= 0;
    end else begin
      scl_r   <= scl_in;
      still_r <= (scl_in != scl_r) ? 0 : still_r + 1;
    end
  end
  a_ptr_kept: assert property ($changed(reg_ptr_out) |-> ##[0:1] ptr_wr_out)
    else $error("pointer moved without a pointer byte");
  a_ptr_pulse: assert property (ptr_wr_out |=> !ptr_wr_out [*8])
    else $error("pointer strobe longer than one cycle");
  a_wr_pulse: assert property (wr_strobe_out |=> !wr_strobe_out [*8])
    else $error("write strobe longer than one cycle");
  a_start_busy: assert property (scl_in && $fell(sda_in) |-> ##[2:8] busy_out)
    else $error("start not seen");
  a_stop_idle: assert property (scl_in && $rose(sda_in) |-> ##[2:8] !busy_out)
    else $error("stop did not return to idle");
  a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data drive changed while clock high");
  a_eot_quiet: assert property (end_of_transfer_marker_out |-> !sda_oe_out [*8])
    else $error("data driven after end of transfer");
  a_alert_od: assert property (!alert_out && alert_oe_out == $past(alert_req_in))
    else $error("alert pin not open drain");
  a_stuck_reset: assert property (still_r == TOUT_CYC + 10 |-> !busy_out && !sda_oe_out)
    else $error("stuck clock did not reset the port");
  c_ptr: cover property (ptr_wr_out);
  c_wr: cover property (wr_strobe_out);
  c_eot: cover property (end_of_transfer_marker_out);
endmodule // tss_chk

bind tss_slave tss_chk #(.TOUT_CYC(TOUT_CYC)) u_chk (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe_out(sda_oe_out), .alert_req_in(alert_req_in), .alert_out(alert_out),
  .alert_oe_out(alert_oe_out), .reg_ptr_out(reg_ptr_out), .ptr_wr_out(ptr_wr_out),
  .wr_strobe_out(wr_strobe_out), .busy_out(busy_out),
  .end_of_transfer_marker_out(end_of_transfer_marker_out)
);

// file: verif/tb_tss_slave.sv
// self-checking bench for the two-wire serial slave port
// assumes the master model owns the clock wire; the data wire is pulled up
`timescale 1ns/1ns
`include "tss_defines.vh"
module tb_tss_slave;
  localparam tout_cyc = 2000;
  reg         mclk_in;
  reg         rstn_in;
  reg         alert_req;
  reg  [2:0]  straps;
  reg  [15:0] rd_data;
  wire        scl_w, m_sda, sda_oe, sda_o, alert_o, alert_oe;
  wire        ptr_wr, wr_stb, rd_ld, busy, eot;
  wire [7:0]  ptr, wdat;
  wire        sda_w = m_sda & (~sda_oe | sda_o);
  integer     num_errors = 0;
  integer     compares = 0;
  reg         a;
  reg  [7:0]  v;
  integer     ptr_cnt_r = 0;
  integer     wr_cnt_r = 0;
  integer     rd_cnt_r = 0;
  integer     eot_cnt_r = 0;
  tss_master m (.mclk_in(mclk_in), .sda_in(sda_w), .scl_out(scl_w), .sda_out(m_sda));
  tss_slave #(.TOUT_CYC(tout_cyc)) uut (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(1'b1), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_strap_bit0_in(straps[0]),
    .addr_strap_bit1_in(straps[1]), .addr_strap_bit2_in(straps[2]), .rd_data_in(rd_data),
    .reg_ptr_out(ptr), .ptr_wr_out(ptr_wr), .wr_data_out(wdat), .wr_strobe_out(wr_stb),
    .rd_load_out(rd_ld), .busy_out(busy), .end_of_transfer_marker_out(eot),
    .alert_req_in(alert_req), .alert_out(alert_o), .alert_oe_out(alert_oe)
  );
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  task chk(input [7:0] got, input [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk_bit(input got, input exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task chk_cnt(input integer got, input integer exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  // strobes stand one cycle, so they are counted as they pass
  always @(posedge mclk_in) begin
    if (ptr_wr === 1'b1) ptr_cnt_r <= ptr_cnt_r + 1;
    if (wr_stb === 1'b1) wr_cnt_r <= wr_cnt_r + 1;
    if (rd_ld === 1'b1) rd_cnt_r <= rd_cnt_r + 1;
    if (eot === 1'b1) eot_cnt_r <= eot_cnt_r + 1;
  end
  task t_write;
    m.start;
    m.wbyte({`TSS_ADDR_CODE, straps, 1'b0}, a);
    chk_bit(a, 1'b1);
    m.wbyte(8'h05, a);
    chk_bit(a, 1'b1);
    chk(ptr, 8'h05);
    chk_cnt(ptr_cnt_r, 1);
    m.wbyte(8'h5a, a);
    chk_bit(a, 1'b1);
    chk(wdat, 8'h5a);
    m.wbyte(8'hc3, a);
    chk(wdat, 8'hc3);
    chk(ptr, 8'h05);
    chk_cnt(wr_cnt_r, 2);
    m.stop;
    chk_bit(busy, 1'b0);
  endtask
  task t_read;
    m.start;
    m.wbyte({`TSS_ADDR_CODE, straps, 1'b1}, a);
    chk_bit(a, 1'b1);
    chk_cnt(rd_cnt_r, 1);
    chk(ptr, 8'h05);
    m.rbyte(1'b0, v);
    chk(v, 8'ha5);
    m.rbyte(1'b1, v);
    chk(v, 8'hc3);
    chk_bit(sda_oe, 1'b0);
    chk_cnt(eot_cnt_r, 1);
    m.stop;
  endtask
  task t_badaddr;
    integer i;
    for (i = 0; i < 2; i++) begin
      m.start;
      m.wbyte(i ? {4'h2, straps, 1'b0} : {`TSS_ADDR_CODE, straps ^ 3'b001, 1'b0}, a);
      chk_bit(a, 1'b0);
      m.wbyte(8'h07, a);
      chk_bit(a, 1'b0);
      m.stop;
    end
    chk(ptr, 8'h05);
    chk_cnt(ptr_cnt_r, 1);
    chk_cnt(wr_cnt_r, 2);
  endtask
  task t_restart;
    integer i;
    @(posedge mclk_in) straps <= 3'b010;
    m.hc(8);
    m.start;
    for (i = 0; i < 4; i++) m.bit_x(i[1], a);
    m.start;
    m.wbyte({`TSS_ADDR_CODE, straps, 1'b0}, a);
    chk_bit(a, 1'b1);
    m.wbyte(8'h02, a);
    chk(ptr, 8'h02);
    chk_cnt(ptr_cnt_r, 2);
    m.stop;
  endtask
  task t_stopmid;
    m.start;
    m.wbyte({`TSS_ADDR_CODE, straps, 1'b1}, a);
    chk_bit(a, 1'b1);
    chk_cnt(rd_cnt_r, 2);
    m.stop;
    chk_bit(sda_oe, 1'b0);
    chk_bit(busy, 1'b0);
  endtask
  // the clock stalls low while the slave holds its address acknowledge
  task t_timeout;
    integer   i;
    reg [7:0] ab;
    ab = {`TSS_ADDR_CODE, straps, 1'b0};
    m.start;
    for (i = 7; i >= 0; i--) m.bit_x(ab[i], a);
    m.hc(tout_cyc / 2);
    chk_bit(sda_oe, 1'b1);
    chk_bit(busy, 1'b1);
    m.hc(tout_cyc / 2 + 50);
    chk_bit(sda_oe, 1'b0);
    chk_bit(busy, 1'b0);
    chk(ptr, 8'h02);
    chk_cnt(ptr_cnt_r, 2);
    m.stop;
  endtask
  task t_alert;
    @(posedge mclk_in) alert_req <= 1'b1;
    m.hc(3);
    chk_bit(alert_oe, 1'b1);
    chk_bit(alert_o, 1'b0);
    alert_req <= 1'b0;
    m.hc(3);
    chk_bit(alert_oe, 1'b0);
  endtask
  initial begin
    rstn_in = 1'b0;
    alert_req = 1'b0;
    straps = 3'b101;
    rd_data = 16'ha5c3;
    repeat (3) @(posedge mclk_in);
    rstn_in <= 1'b1;
    m.hc(6);
    t_write;
    t_read;
    t_badaddr;
    t_restart;
    t_stopmid;
    t_timeout;
    t_alert;
    tally_and_finish;
  end
  // the whole run needs about 22 us; a hang counts as a failure
  initial begin
    #200000;
    num_errors++;
    tally_and_finish;
  end
endmodule // tb_tss_slave
